/* acp_pkg.sv */
`default_nettype none
package acp_pkg;
   // Register byte offsets on the APB slave.
   localparam logic [7:0] ACP_OFS_CTRL = 8'h00;
   localparam logic [7:0] ACP_OFS_POLL = 8'h04;
   localparam logic [7:0] ACP_OFS_TX_PORT = 8'h08;
   localparam logic [7:0] ACP_OFS_RX_PORT = 8'h0c;
   localparam logic [7:0] ACP_OFS_TX_DATA = 8'h10;
   localparam logic [7:0] ACP_OFS_RX_DATA = 8'h14;
   localparam logic [7:0] ACP_OFS_STATUS = 8'h18;
   localparam logic [7:0] ACP_OFS_PORT_STAT = 8'h1c;
   // Control register fields.
   localparam int ACP_CTRL_MULTI = 0;
   localparam int ACP_CTRL_OCTET = 1;
   localparam int ACP_CTRL_HEC = 2;
   localparam int ACP_CTRL_COSET = 3;
   localparam int ACP_CTRL_TXEN = 4;
   localparam int ACP_CTRL_RXEN = 5;
   localparam int ACP_CTRL_W = 6;
   localparam logic [5:0] ACP_CTRL_RST = 6'h00;
   // Status register fields.
   localparam int ACP_ST_TXFULL = 0;
   localparam int ACP_ST_RXFULL = 2;
   localparam int ACP_ST_TXBUSY = 4;
   // Device addressing and polling.
   localparam int ACP_ADDR_W = 5;
   localparam logic [4:0] ACP_SINGLE_ADDR = 5'h1f;
   localparam logic [4:0] ACP_POLL_MAX = 5'h19;
   localparam logic [4:0] ACP_POLL_RST = 5'h00;
   localparam logic [4:0] ACP_PORT_RST = 5'h00;
   // Cell layout.
   localparam logic [5:0] ACP_CELL_LAST = 6'h34;
   localparam logic [5:0] ACP_LOAD_LAST_HEC = 6'h33;
   localparam logic [5:0] ACP_HEC_POS = 6'h04;
   localparam int ACP_BUF_BYTES = 64;
   localparam logic [7:0] ACP_COSET = 8'h55;
   localparam logic [7:0] ACP_CRC_POLY = 8'h07;
   localparam int ACP_RX_MARGIN = 4;

   typedef enum logic [2:0] {
      ACP_TX_IDLE = 3'b001,
      ACP_TX_SEL = 3'b010,
      ACP_TX_SEND = 3'b100
   } acp_tx_state_t;

   // Header checksum residue update for one byte.
   function automatic logic [7:0] acp_crc8(input logic [7:0] crc,
                                           input logic [7:0] d);
      logic [7:0] c;
      c = crc ^ d;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ ACP_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : acp_crc8
endpackage : acp_pkg
`default_nettype wire

/* acp_top.sv */
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module acp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   input wire logic out_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("FIFO depth must be a power of two of at least two.");
      end
   endgenerate
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;
   assign level = wr_ptr - rd_ptr;
   assign in_ready = level != (AW+1)'(DEPTH);
   assign out_valid = level != '0;
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule : acp_fifo
////////////////////////////////////////////////////////////////////////////////
module acp_top import acp_pkg::*; #(
   parameter int RX_FIFO_DEPTH = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_clk,
   output logic [7:0] tx_data,
   output logic tx_soc,
   output logic tx_enb_n,
   input wire logic tx_clav,
   output logic [ACP_ADDR_W-1:0] transmit_device_select,
   input wire logic [7:0] rx_data,
   input wire logic rx_soc,
   output logic rx_enb_n,
   input wire logic rx_clav,
   output logic [ACP_ADDR_W-1:0] receive_device_select
);
   generate
      if (RX_FIFO_DEPTH < 2 * ACP_RX_MARGIN) begin : g_bad_fifo
         $error("Receive FIFO too shallow for the stop margin.");
      end
   endgenerate
   localparam int LW = $clog2(RX_FIFO_DEPTH) + 1;
   localparam logic [LW-1:0] RX_STOP = LW'(RX_FIFO_DEPTH - ACP_RX_MARGIN);

   logic [ACP_CTRL_W-1:0] ctrl;
   logic [4:0] poll_limit;
   logic [4:0] tx_port;
   logic [4:0] rx_port;
   logic [4:0] next_poll_limit;
   logic apb_req;
   logic apb_done;
   logic tx_wr;
   logic rx_rd;
   logic [7:0] tx_mem [0:2*ACP_BUF_BYTES-1];
   logic [7:0] rx_mem [0:2*ACP_BUF_BYTES-1];
   logic [1:0] tx_full;
   logic [1:0] rx_full;
   logic tx_wr_buf;
   logic tx_rd_buf;
   logic rx_wr_buf;
   logic rx_rd_buf;
   logic [5:0] tx_wr_idx;
   logic [5:0] rx_wr_idx;
   logic [5:0] rx_rd_idx;
   logic [4:0] tx_cell_port [0:1];
   logic [5:0] load_last;
   logic [11:0] sync_a;
   logic [11:0] sync_b;
   logic link_prev;
   logic link_rise;
   logic tx_clav_s;
   logic rx_clav_s;
   acp_tx_state_t tx_state;
   logic [5:0] tx_cnt;
   logic [5:0] tx_src_idx;
   logic [7:0] crc;
   logic [7:0] hec_byte;
   logic can_go;
   logic tx_last;
   logic go_sel;
   logic go_send;
   logic poll_phase;
   logic [4:0] poll_idx;
   logic [31:0] port_status;
   logic rx_push;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [8:0] fifo_out;
   logic [LW-1:0] fifo_level;
   logic [5:0] rx_pos;

   ////////////////////////////////////////////////////////////////////////////
   // Core interface: APB slave with one wait state.
   assign apb_req = psel & penable & ~pready;
   assign apb_done = psel & penable & pready & ~pslverr;
   assign tx_wr = apb_done & pwrite & (paddr == ACP_OFS_TX_DATA);
   assign rx_rd = apb_done & ~pwrite & (paddr == ACP_OFS_RX_DATA);
   assign next_poll_limit = (pwdata[4:0] > ACP_POLL_MAX) ?
                            ACP_POLL_MAX : pwdata[4:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= apb_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (apb_req) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (paddr == ACP_OFS_CTRL) begin
            prdata[ACP_CTRL_W-1:0] <= ctrl;
         end else if (paddr == ACP_OFS_POLL) begin
            prdata[4:0] <= poll_limit;
         end else if (paddr == ACP_OFS_TX_PORT) begin
            prdata[4:0] <= tx_port;
         end else if (paddr == ACP_OFS_RX_PORT) begin
            prdata[4:0] <= rx_port;
         end else if (paddr == ACP_OFS_TX_DATA) begin
            pslverr <= pwrite & tx_full[tx_wr_buf];
         end else if (paddr == ACP_OFS_RX_DATA) begin
            pslverr <= ~pwrite & ~rx_full[rx_rd_buf];
            prdata[7:0] <= rx_full[rx_rd_buf] ?
                           rx_mem[{rx_rd_buf, rx_rd_idx}] : 8'h00;
         end else if (paddr == ACP_OFS_STATUS) begin
            prdata[ACP_ST_TXFULL +: 2] <= tx_full;
            prdata[ACP_ST_RXFULL +: 2] <= rx_full;
            prdata[ACP_ST_TXBUSY] <= tx_state != ACP_TX_IDLE;
         end else if (paddr == ACP_OFS_PORT_STAT) begin
            prdata <= port_status;
         end else begin
            pslverr <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= ACP_CTRL_RST;
         poll_limit <= ACP_POLL_RST;
         tx_port <= ACP_PORT_RST;
         rx_port <= ACP_PORT_RST;
      end else if (apb_done && pwrite) begin
         if (paddr == ACP_OFS_CTRL) begin
            ctrl <= pwdata[ACP_CTRL_W-1:0];
         end else if (paddr == ACP_OFS_POLL) begin
            poll_limit <= next_poll_limit;
         end else if (paddr == ACP_OFS_TX_PORT) begin
            tx_port <= pwdata[4:0];
         end else if (paddr == ACP_OFS_RX_PORT) begin
            rx_port <= pwdata[4:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit cell buffers: core fills one while the link drains the other.
   assign load_last = ctrl[ACP_CTRL_HEC] ? ACP_LOAD_LAST_HEC : ACP_CELL_LAST;

   always_ff @(posedge pclk) begin
      if (tx_wr) begin
         tx_mem[{tx_wr_buf, tx_wr_idx}] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_wr_buf <= 1'b0;
         tx_wr_idx <= 6'h00;
         tx_cell_port[0] <= ACP_PORT_RST;
         tx_cell_port[1] <= ACP_PORT_RST;
      end else if (tx_wr) begin
         if (tx_wr_idx == load_last) begin
            tx_wr_idx <= 6'h00;
            tx_wr_buf <= ~tx_wr_buf;
            tx_cell_port[tx_wr_buf] <= tx_port;
         end else begin
            tx_wr_idx <= tx_wr_idx + 6'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_full <= 2'b00;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (tx_wr && tx_wr_idx == load_last && tx_wr_buf == b[0]) begin
               tx_full[b] <= 1'b1;
            end else if (tx_last && tx_rd_buf == b[0]) begin
               tx_full[b] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link inputs: two flip-flops, then edge detection on the link clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 12'h000;
         sync_b <= 12'h000;
         link_prev <= 1'b0;
      end else begin
         sync_a <= {link_clk, tx_clav, rx_clav, rx_soc, rx_data};
         sync_b <= sync_a;
         link_prev <= sync_b[11];
      end
   end
   assign link_rise = sync_b[11] & ~link_prev;
   assign tx_clav_s = sync_b[10];
   assign rx_clav_s = sync_b[9];

   ////////////////////////////////////////////////////////////////////////////
   // Transmit module.
   assign tx_src_idx = (ctrl[ACP_CTRL_HEC] && tx_cnt > ACP_HEC_POS) ?
                       6'(tx_cnt - 6'h01) : tx_cnt;
   assign hec_byte = crc ^ (ctrl[ACP_CTRL_COSET] ? ACP_COSET : 8'h00);
   assign can_go = ctrl[ACP_CTRL_MULTI] | ~ctrl[ACP_CTRL_OCTET] |
                   tx_clav_s;
   assign tx_last = link_rise & (tx_state == ACP_TX_SEND) & can_go &
                    (tx_cnt == ACP_CELL_LAST);
   assign go_sel = ctrl[ACP_CTRL_TXEN] & tx_full[tx_rd_buf] &
                   ctrl[ACP_CTRL_MULTI] &
                   port_status[tx_cell_port[tx_rd_buf]];
   assign go_send = ctrl[ACP_CTRL_TXEN] & tx_full[tx_rd_buf] &
                    ~ctrl[ACP_CTRL_MULTI] & tx_clav_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= ACP_TX_IDLE;
         tx_cnt <= 6'h00;
         crc <= 8'h00;
         tx_data <= 8'h00;
         tx_soc <= 1'b0;
         tx_enb_n <= 1'b1;
         tx_rd_buf <= 1'b0;
      end else if (link_rise) begin
         case (tx_state)
            ACP_TX_IDLE: begin
               tx_enb_n <= 1'b1;
               tx_soc <= 1'b0;
               tx_cnt <= 6'h00;
               crc <= 8'h00;
               if (go_sel) begin
                  tx_state <= ACP_TX_SEL;
               end else if (go_send) begin
                  tx_state <= ACP_TX_SEND;
               end
            end
            ACP_TX_SEL: begin
               tx_state <= ACP_TX_SEND;
            end
            ACP_TX_SEND: begin
               if (can_go) begin
                  tx_enb_n <= 1'b0;
                  tx_soc <= tx_cnt == 6'h00;
                  if (ctrl[ACP_CTRL_HEC] && tx_cnt == ACP_HEC_POS) begin
                     tx_data <= hec_byte;
                  end else begin
                     tx_data <= tx_mem[{tx_rd_buf, tx_src_idx}];
                  end
                  if (tx_cnt < ACP_HEC_POS) begin
                     crc <= acp_crc8(crc, tx_mem[{tx_rd_buf, tx_src_idx}]);
                  end
                  tx_cnt <= tx_cnt + 6'h01;
                  if (tx_cnt == ACP_CELL_LAST) begin
                     tx_state <= ACP_TX_IDLE;
                     tx_rd_buf <= ~tx_rd_buf;
                  end
               end else begin
                  tx_enb_n <= 1'b1;
                  tx_soc <= 1'b0;
               end
            end
            default: begin
               tx_state <= ACP_TX_IDLE;
            end
         endcase
      end
   end

   // Round-robin polling: drive an address, sample readiness next link cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         poll_phase <= 1'b0;
         poll_idx <= ACP_POLL_RST;
         port_status <= 32'h0000_0000;
      end else if (!ctrl[ACP_CTRL_MULTI]) begin
         poll_phase <= 1'b0;
         poll_idx <= ACP_POLL_RST;
      end else if (link_rise && tx_state == ACP_TX_IDLE) begin
         if (go_sel) begin
            port_status[tx_cell_port[tx_rd_buf]] <= 1'b0;
         end
         poll_phase <= ~poll_phase;
         if (poll_phase) begin
            port_status[poll_idx] <= tx_clav_s;
            poll_idx <= (poll_idx >= poll_limit) ?
                        ACP_POLL_RST : poll_idx + 5'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_device_select <= ACP_SINGLE_ADDR;
         receive_device_select <= ACP_SINGLE_ADDR;
      end else if (!ctrl[ACP_CTRL_MULTI]) begin
         transmit_device_select <= ACP_SINGLE_ADDR;
         receive_device_select <= ACP_SINGLE_ADDR;
      end else begin
         receive_device_select <= rx_port;
         if (link_rise && tx_state == ACP_TX_IDLE) begin
            if (go_sel) begin
               transmit_device_select <= tx_cell_port[tx_rd_buf];
            end else if (!poll_phase) begin
               transmit_device_select <= poll_idx;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive module: link bytes enter a FIFO, which drains into cell buffers.
   assign rx_push = link_rise & ~rx_enb_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_enb_n <= 1'b1;
      end else if (link_rise) begin
         rx_enb_n <= ~(ctrl[ACP_CTRL_RXEN] & rx_clav_s &
                       (fifo_level <= RX_STOP));
      end
   end

   acp_fifo #(.WIDTH(9), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(rx_push),
      .in_data(sync_b[8:0]),
      .in_ready(fifo_in_ready),
      .out_ready(fifo_out_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out),
      .level(fifo_level)
   );

   assign fifo_out_ready = ~rx_full[rx_wr_buf];
   assign rx_pos = fifo_out[8] ? 6'h00 : rx_wr_idx;

   always_ff @(posedge pclk) begin
      if (fifo_out_valid && fifo_out_ready) begin
         rx_mem[{rx_wr_buf, rx_pos}] <= fifo_out[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wr_buf <= 1'b0;
         rx_wr_idx <= 6'h00;
      end else if (fifo_out_valid && fifo_out_ready) begin
         if (rx_pos == ACP_CELL_LAST) begin
            rx_wr_idx <= 6'h00;
            rx_wr_buf <= ~rx_wr_buf;
         end else begin
            rx_wr_idx <= rx_pos + 6'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_rd_buf <= 1'b0;
         rx_rd_idx <= 6'h00;
      end else if (rx_rd) begin
         if (rx_rd_idx == ACP_CELL_LAST) begin
            rx_rd_idx <= 6'h00;
            rx_rd_buf <= ~rx_rd_buf;
         end else begin
            rx_rd_idx <= rx_rd_idx + 6'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_full <= 2'b00;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (fifo_out_valid && fifo_out_ready &&
                rx_pos == ACP_CELL_LAST && rx_wr_buf == b[0]) begin
               rx_full[b] <= 1'b1;
            end else if (rx_rd && rx_rd_idx == ACP_CELL_LAST &&
                         rx_rd_buf == b[0]) begin
               rx_full[b] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking acp_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence hec_slot_s;
      link_rise && tx_state == ACP_TX_SEND && can_go &&
      ctrl[ACP_CTRL_HEC] && tx_cnt == ACP_HEC_POS;
   endsequence
   sequence last_byte_s;
      tx_last;
   endsequence

   single_select_a: assert property (
      $past(!ctrl[ACP_CTRL_MULTI]) |->
         transmit_device_select == ACP_SINGLE_ADDR &&
         receive_device_select == ACP_SINGLE_ADDR)
      else $error("Single mode select lines not all ones.");
   poll_bound_a: assert property (
      poll_limit <= ACP_POLL_MAX && poll_idx <= ACP_POLL_MAX)
      else $error("Polling range exceeds 26 devices.");
   poll_wrap_a: assert property (
      (link_rise && ctrl[ACP_CTRL_MULTI] && tx_state == ACP_TX_IDLE &&
       poll_phase && poll_idx >= poll_limit) |=> poll_idx == 5'h00)
      else $error("Polling did not wrap to address zero.");
   send_holds_cell_a: assert property (
      $fell(tx_enb_n) |->
         $past(tx_full[tx_rd_buf] && tx_state == ACP_TX_SEND))
      else $error("Transmit enable without a loaded cell.");
   multi_cell_a: assert property (
      (link_rise && tx_state == ACP_TX_SEND && ctrl[ACP_CTRL_MULTI])
         |=> !tx_enb_n)
      else $error("Cell paused in multiple device mode.");
   hec_value_a: assert property (
      hec_slot_s |=> tx_data == (crc ^ (ctrl[ACP_CTRL_COSET] ?
                                        ACP_COSET : 8'h00)))
      else $error("Inserted checksum byte is wrong.");
   cell_release_a: assert property (
      last_byte_s |=> tx_state == ACP_TX_IDLE &&
                      tx_rd_buf != $past(tx_rd_buf) &&
                      !tx_full[$past(tx_rd_buf)])
      else $error("Drained cell buffer not released.");
   rx_space_a: assert property (
      rx_push |-> fifo_in_ready)
      else $error("Receive byte arrived with FIFO full.");
   soc_first_a: assert property (
      tx_soc |-> !tx_enb_n && tx_cnt == 6'h01)
      else $error("Start of cell not on first byte.");
endmodule : acp_top
`default_nettype wire

/* acp_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acp_phy_model (
   input wire logic link_clk,
   input wire logic [7:0] tx_data,
   input wire logic tx_soc,
   input wire logic tx_enb_n,
   input wire logic rx_enb_n,
   input wire logic rx_go,
   input wire logic tx_pause,
   output logic tx_clav,
   output logic [7:0] rx_data,
   output logic rx_soc,
   output logic rx_clav
);
   logic [8:0] txq[$];
   int k = 0;
   logic took = 1'b0;
   assign tx_clav = !tx_pause;
   initial begin
      rx_data = 8'h00;
      rx_soc = 1'b0;
      rx_clav = 1'b0;
   end
   always @(posedge link_clk) begin
      if (!tx_enb_n) txq.push_back({tx_soc, tx_data});
      took <= rx_clav && !rx_enb_n;
   end
   // Receive lines move on the falling edge, clear of the sampling edge.
   always @(negedge link_clk) begin
      if (took) k = k + 1;
      rx_clav <= rx_go && k < 53;
      rx_soc <= rx_go && k == 0;
      rx_data <= (rx_go && k < 53) ? 8'(8'h80 + k) : ~rx_data;
   end
endmodule : acp_phy_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb import acp_pkg::*;;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic link_clk = 0, rx_go = 0;
   logic tx_pause = 0, pause_en = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, er, tx_soc, tx_enb_n, tx_clav;
   logic rx_soc, rx_enb_n, rx_clav;
   logic [7:0] tx_data, rx_data;
   logic [4:0] tsel, rsel;
   int err_count = 0, n_checks = 0, cyc = 0;
   acp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_clk(link_clk), .tx_data(tx_data), .tx_soc(tx_soc),
      .tx_enb_n(tx_enb_n), .tx_clav(tx_clav), .transmit_device_select(tsel),
      .rx_data(rx_data), .rx_soc(rx_soc), .rx_enb_n(rx_enb_n),
      .rx_clav(rx_clav), .receive_device_select(rsel));
   acp_phy_model phy (.link_clk(link_clk), .tx_data(tx_data),
      .tx_soc(tx_soc), .tx_enb_n(tx_enb_n), .rx_enb_n(rx_enb_n),
      .rx_go(rx_go), .tx_pause(tx_pause), .tx_clav(tx_clav),
      .rx_data(rx_data), .rx_soc(rx_soc), .rx_clav(rx_clav));
   initial forever #5 pclk = ~pclk;
   initial begin
      #3;
      forever #40 link_clk = ~link_clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   always @(posedge pclk) begin
      cyc++;
      tx_pause <= pause_en && cyc[5:4] == 2'b11;
      if (cyc == 30000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] ex, sn);
      n_checks++;
      if (sn !== ex) begin
         $display("mismatch %s expected %h seen %h", nm, ex, sn);
         err_count++;
      end
   endtask : chk
   // One APB transfer; waits for pready, with no bound of its own.
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   function automatic logic [7:0] hec(input logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 3; i >= 0; i--) begin
         c = c ^ h[i*8 +: 8];
         for (int j = 0; j < 8; j++) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
      end
      return c;
   endfunction : hec
   task automatic s_regs();
      chk("tx_enb_n", 1, tx_enb_n);
      chk("tx_sel", 5'h1f, tsel);
      apb(0, ACP_OFS_STATUS, 0);
      chk("status", 0, rd);
      apb(1, ACP_OFS_CTRL, 3);
      apb(0, ACP_OFS_CTRL, 0);
      chk("ctrl", 3, rd);
      apb(1, ACP_OFS_POLL, 31);
      apb(0, ACP_OFS_POLL, 0);
      chk("poll", 25, rd);
      apb(0, 8'h20, 0);
      chk("slverr", 1, er);
   endtask : s_regs
   // Two cells loaded back to back; the second fills while the first drains.
   task automatic s_tx(input logic [31:0] c);
      logic [7:0] e;
      int n;
      phy.txq.delete();
      pause_en <= c[1];
      apb(1, ACP_OFS_CTRL, c | 32'h10);
      for (int k = 0; k < 2; k++)
         for (int i = 0; i < 53; i++)
            if (!(c[2] && i == 4)) apb(1, ACP_OFS_TX_DATA, 32 * k + i + 1);
      n = 0;
      while (phy.txq.size() < 106 && n++ < 5000) @(posedge pclk);
      chk("tx count", 106, phy.txq.size());
      for (int k = 0; k < 2; k++)
         for (int i = 0; i < 53; i++) begin
            e = 8'(32 * k + i + 1);
            if (c[2] && i == 4)
               e = hec({e-8'h4, e-8'h3, e-8'h2, e-8'h1}) ^ (c[3] ? 8'h55 : 8'h00);
            chk("tx byte", {i == 0, e}, phy.txq[k*53+i]);
         end
      chk("tx_sel", 5'h1f, tsel);
   endtask : s_tx
   task automatic s_multi();
      logic [31:0] seen;
      logic [4:0] sel;
      int n;
      seen = 0;
      sel = 0;
      n = 0;
      apb(1, ACP_OFS_POLL, 2);
      apb(1, ACP_OFS_RX_PORT, 7);
      apb(1, ACP_OFS_CTRL, 32'h11);
      // The first link edge replaces the single-mode select value.
      repeat (16) @(posedge pclk);
      repeat (600) begin
         @(posedge pclk);
         seen[tsel] = 1'b1;
      end
      chk("polled", 32'h7, seen);
      chk("rx_sel", 7, rsel);
      apb(0, ACP_OFS_PORT_STAT, 0);
      chk("port stat", 32'h7, rd);
      phy.txq.delete();
      apb(1, ACP_OFS_TX_PORT, 1);
      for (int i = 0; i < 53; i++) apb(1, ACP_OFS_TX_DATA, i + 1);
      while (phy.txq.size() < 53 && n++ < 2000) begin
         @(posedge pclk);
         if (!tx_enb_n) sel = tsel;
      end
      chk("multi count", 53, phy.txq.size());
      chk("multi first", 9'h101, phy.txq[0]);
      chk("multi last", 9'h035, phy.txq[52]);
      chk("multi sel", 1, sel);
   endtask : s_multi
   task automatic s_rx();
      int n;
      apb(1, ACP_OFS_CTRL, 32'h20);
      rx_go <= 1;
      n = 0;
      do apb(0, ACP_OFS_STATUS, 0); while (rd[3:2] == 0 && n++ < 300);
      for (int i = 0; i < 53; i++) begin
         apb(0, ACP_OFS_RX_DATA, 0);
         chk("rx byte", 8'h80 + i, rd);
      end
      apb(0, ACP_OFS_RX_DATA, 0);
      chk("rx empty", 1, er);
   endtask : s_rx
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      s_regs();
      s_tx(0);
      s_tx(32'h4);
      s_tx(32'h6);
      s_tx(32'hc);
      s_multi();
      s_rx();
      complete_run();
   end
endmodule : tb
`default_nettype wire
